// ### geom_pkg.sv
// geometry constants, types and state codes for the binning / row skip block
// assumes one pixel clock domain; no other file defines these names
`default_nettype none

package geom_pkg;

    // widths
    localparam int DIM_W  = 16;             // image dimension width
    localparam int FAC_W  = 3;              // binning factor width
    localparam int SKIP_W = 6;              // row skip factor width
    localparam int PIX_W  = 12;             // pixel data width
    localparam int NZONE  = 2;              // stacked zones
    localparam int NFIELD = 6 + 2 * NZONE;  // geometry fields held
    localparam int FIDX_W = 4;              // field index width

    // factor codes
    localparam logic [FAC_W-1:0]  FAC_OFF  = 3'h1;  // binning disabled
    localparam logic [FAC_W-1:0]  FAC_MAX  = 3'h4;  // largest binning factor
    localparam logic [SKIP_W-1:0] SKIP_OFF = 6'h01; // row skipping disabled
    localparam logic [SKIP_W-1:0] SKIP_MAX = 6'h20; // largest row skip factor

    // geometry field indices (zone k: y at ZONE_Y0+2k, height at +1)
    localparam logic [FIDX_W-1:0] F_ROI_W   = 4'h0;
    localparam logic [FIDX_W-1:0] F_ROI_H   = 4'h1;
    localparam logic [FIDX_W-1:0] F_OFF_X   = 4'h2;
    localparam logic [FIDX_W-1:0] F_OFF_Y   = 4'h3;
    localparam logic [FIDX_W-1:0] F_ZONE_X  = 4'h4;
    localparam logic [FIDX_W-1:0] F_ZONE_W  = 4'h5;
    localparam logic [FIDX_W-1:0] F_ZONE_Y0 = 4'h6;

    // fields scaled by the horizontal factor (others use vertical)
    localparam logic [NFIELD-1:0] HORIZ_MASK = 10'h035;

    // default sensor size
    localparam logic [DIM_W-1:0] SENSOR_W_DEF = 16'h0400;
    localparam logic [DIM_W-1:0] SENSOR_H_DEF = 16'h0300;
    localparam logic [DIM_W-1:0] DIM_ONE      = 16'h0001;

    typedef logic [DIM_W-1:0]  dim_t;
    typedef logic [FAC_W-1:0]  fac_t;
    typedef logic [SKIP_W-1:0] skip_t;

    // rescale walker states
    typedef enum logic {
        ST_IDLE  = 1'b0,
        ST_SCALE = 1'b1
    } scale_st_t;

    // position of the current row
    typedef struct packed {
        fac_t  vphase;  // row inside binning group
        dim_t  vgrp;    // binning group number
        skip_t dphase;  // unit inside skip cycle
        logic  pair;    // second row of a colour pair
    } row_st_t;

endpackage

`default_nettype wire

// ### geom_link_if.sv
// carrier between the block top and its row selector
// assumes both ends run on the same pixel clock
`default_nettype none

interface geom_link_if;
    import geom_pkg::*;
    logic  sof;        // first pixel of frame
    logic  sol;        // first pixel of row
    fac_t  bin_v;      // vertical factor for this frame
    skip_t skip;       // row skip factor for this frame
    dim_t  eff_h;      // binned height for this frame
    logic  row_keep;   // current row is sent
    logic  vgrp_last;  // current row closes its binning group
    logic  next_keep;  // following row will be sent

    modport cfg (output sof, sol, bin_v, skip, eff_h, input row_keep, vgrp_last, next_keep);
    modport sel (input sof, sol, bin_v, skip, eff_h, output row_keep, vgrp_last, next_keep);
endinterface

`default_nettype wire

// ### div_small.sv
// divider of a dimension by a binning factor, truncating
// assumes a factor of zero never arrives; it then passes the value through
`default_nettype none

module div_small
    import geom_pkg::*;
(
    // operands
    input  wire logic [DIM_W+1:0] num,
    input  wire fac_t             fac,
    // result
    output logic [DIM_W+1:0]      quo
);

    // integer division rounds toward zero
    always_comb begin
        if (fac == '0) begin
            quo = num;
        end else begin
            quo = num / (DIM_W+2)'(fac);
        end
    end

endmodule

`default_nettype wire

// ### row_selector.sv
// row selector: binning group position, drop of partial groups, row skipping
// assumes sol and sof are qualified by pixel valid in the top
`default_nettype none

module row_selector
    import geom_pkg::*;
#(
    parameter bit IS_COLOUR = 1'b0
)(
    // clock and control
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic ce,
    // link to top
    geom_link_if.sel  lnk
);

    row_st_t st_q;     // state of the last started row
    logic    first_q;  // next row is row 0
    row_st_t cur;      // state of the row now on the bus
    row_st_t nxt;      // state of the row after it

    // step to the following row
    function automatic row_st_t adv(row_st_t s, fac_t bv, skip_t n);
        row_st_t r;
        r = s;
        // vertical binning group
        if (s.vphase >= bv - FAC_OFF) begin
            r.vphase = '0;
            r.vgrp   = s.vgrp + DIM_ONE;
        end else begin
            r.vphase = s.vphase + FAC_OFF;
        end
        // colour keeps pairs together, mono steps per row
        if (!IS_COLOUR || s.pair) begin
            r.pair   = 1'b0;
            r.dphase = (s.dphase >= n - SKIP_OFF) ? '0 : s.dphase + SKIP_OFF;
        end else begin
            r.pair   = 1'b1;
        end
        return r;
    endfunction

    // row is sent when its group is whole and its unit is first of cycle
    function automatic logic keep(row_st_t s, dim_t eh);
        return (s.vgrp < eh) && (s.dphase == '0);
    endfunction

    // current and following row
    always_comb begin
        if (lnk.sol) begin
            cur = (first_q || lnk.sof) ? '0 : adv(st_q, lnk.bin_v, lnk.skip);
        end else begin
            cur = st_q;
        end
        nxt = adv(cur, lnk.bin_v, lnk.skip);
    end

    // row state
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_q    <= '0;
            first_q <= 1'b1;
        end else if (ce) begin
            if (lnk.sol) begin
                st_q    <= cur;
                first_q <= 1'b0;
            end else if (lnk.sof) begin
                first_q <= 1'b1;
            end
        end
    end

    // answers to the top
    assign lnk.row_keep  = keep(cur, lnk.eff_h);
    assign lnk.vgrp_last = (cur.vphase == lnk.bin_v - FAC_OFF);
    assign lnk.next_keep = keep(nxt, lnk.eff_h);

endmodule

`default_nettype wire

// ### pixel_binning_decimation.sv
// binning and row skip geometry for the pixel path, with region rescaling
// assumes pixel stream and settings come from logic on mclk
//
// Operation
// - factor 2, 3, 4 bins; 1 disables
// - binned size is sensor size over factor
// - partial binning groups are dropped entirely
// - region limits and values shrink when binning
// - offsets in binned coordinates, rescaled on change
// - disabling multiplies back; lost remainder stays lost
// - binning off restores full sensor size
// - vertical binning and row skipping exclude each other
// - horizontal binning ignores row skip setting
// - stacked zone values divided by factor
// - mono vertical binning lowers minimum gain limit
// - row skip factor one sends every row
// - mono factor two sends one row in two
// - colour factor two sends alternate row pairs
// - skipped rows shorten readout, raising frame rate
`default_nettype none

module pixel_binning_decimation
    import geom_pkg::*;
#(
    parameter dim_t SENSOR_W  = SENSOR_W_DEF,
    parameter dim_t SENSOR_H  = SENSOR_H_DEF,
    parameter bit   IS_COLOUR = 1'b0
)(
    // clock, reset, enable
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire logic              ce,
    // factor settings
    input  wire logic              bin_h_wr,
    input  wire logic              bin_v_wr,
    input  wire logic              row_skip_factor_wr,
    input  wire skip_t             set_wdata,
    // geometry access
    input  wire logic              geom_wr,
    input  wire logic [FIDX_W-1:0] geom_idx,
    input  wire dim_t              geom_wdata,
    input  wire logic [FIDX_W-1:0] geom_rd_idx,
    // sensor pixel stream
    input  wire logic              pix_valid,
    input  wire logic              pix_sof,
    input  wire logic              pix_sol,
    input  wire logic [PIX_W-1:0]  pix_data,
    // transmit pixel stream
    output logic                   out_valid_q,
    output logic                   out_sof_q,
    output logic [PIX_W-1:0]       out_data_q,
    output logic                   out_hlast_q,
    output logic                   out_vlast_q,
    // sensor readout hint
    output logic                   row_skip_next_q,
    // status
    output fac_t                   bin_h_q,
    output fac_t                   bin_v_q,
    output skip_t                  row_skip_factor_q,
    output dim_t                   eff_width_q,
    output dim_t                   eff_height_q,
    output dim_t                   geom_rdata_q,
    output logic                   busy_q,
    output logic                   gain_min_low_q
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    ////////////////////////////////////////////////////////////////////////

    geom_link_if lnk ();                 // link to row selector

    logic               fac_ok;          // legal binning value
    logic               skip_ok;         // legal row skip value
    logic [DIM_W+1:0]   quo_w;           // sensor width over factor
    logic [DIM_W+1:0]   quo_h;           // sensor height over factor

    dim_t               geom_q [NFIELD]; // region, offsets, zones
    scale_st_t          st_q;            // rescale walker state
    logic [FIDX_W-1:0]  idx_q;           // field being rescaled
    fac_t               app_h_q;         // factor the fields are in
    fac_t               app_v_q;
    fac_t               old_h_q;         // factors of the current walk
    fac_t               old_v_q;
    fac_t               new_h_q;
    fac_t               new_v_q;
    logic               pending;         // factor changed, fields stale
    logic               cur_horiz;       // walked field is horizontal
    fac_t               f_old;
    fac_t               f_new;
    logic [DIM_W+1:0]   prod;            // field times old factor
    logic [DIM_W+1:0]   sc_quo;          // over new factor
    dim_t               sc_val;          // saturated, clamped result
    dim_t               wr_val;          // clamped write value
    logic               geom_ok;         // write is taken

    fac_t               bin_h_act_q;     // factors of the running frame
    fac_t               bin_v_act_q;
    skip_t              skip_act_q;
    dim_t               eff_w_act_q;
    dim_t               eff_h_act_q;
    fac_t               hfac;            // horizontal factor in force
    dim_t               hmax;            // binned width in force
    fac_t               hphase_q;        // column inside group
    dim_t               hgrp_q;          // horizontal group number
    fac_t               hcur_ph;
    dim_t               hcur_grp;
    logic               col_keep;        // column in a whole group
    logic               hlast;           // column closes its group

    ////////////////////////////////////////////////////////////////////////
    // factor settings
    ////////////////////////////////////////////////////////////////////////

    // legality of written values
    assign fac_ok  = (set_wdata >= SKIP_OFF) && (set_wdata <= SKIP_W'(FAC_MAX));
    assign skip_ok = (set_wdata >= SKIP_OFF) && (set_wdata <= SKIP_MAX);

    // factor registers; illegal values ignored, vertical binning write wins a tie with row skip
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            bin_h_q           <= FAC_OFF;
            bin_v_q           <= FAC_OFF;
            row_skip_factor_q <= SKIP_OFF;
        end else if (ce) begin
            if (bin_h_wr && fac_ok) begin
                bin_h_q <= set_wdata[FAC_W-1:0];
            end
            if (bin_v_wr && fac_ok) begin
                bin_v_q <= set_wdata[FAC_W-1:0];
                if (set_wdata != SKIP_OFF) begin
                    row_skip_factor_q <= SKIP_OFF;
                end
            end else if (row_skip_factor_wr && skip_ok) begin
                row_skip_factor_q <= set_wdata;
                if (set_wdata != SKIP_OFF) begin
                    bin_v_q <= FAC_OFF;
                end
            end
        end
    end

    // minimum gain limit lowers on mono with vertical binning
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            gain_min_low_q <= 1'b0;
        end else if (ce) begin
            gain_min_low_q <= !IS_COLOUR && (bin_v_q != FAC_OFF);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // effective resolution
    ////////////////////////////////////////////////////////////////////////

    div_small u_div_w (
        .num ({2'b00, SENSOR_W}),
        .fac (bin_h_q),
        .quo (quo_w)
    );

    div_small u_div_h (
        .num ({2'b00, SENSOR_H}),
        .fac (bin_v_q),
        .quo (quo_h)
    );

    // binned virtual sensor; factor one gives full size
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            eff_width_q  <= SENSOR_W;
            eff_height_q <= SENSOR_H;
        end else if (ce) begin
            eff_width_q  <= quo_w[DIM_W-1:0];
            eff_height_q <= quo_h[DIM_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // geometry rescale walker
    ////////////////////////////////////////////////////////////////////////

    assign pending   = (bin_h_q != app_h_q) || (bin_v_q != app_v_q);
    assign cur_horiz = HORIZ_MASK[idx_q];
    assign f_old     = cur_horiz ? old_h_q : old_v_q;
    assign f_new     = cur_horiz ? new_h_q : new_v_q;
    assign prod      = {2'b00, geom_q[idx_q]} * {{(DIM_W-1){1'b0}}, f_old};

    div_small u_div_s (
        .num (prod),
        .fac (f_new),
        .quo (sc_quo)
    );

    // saturate, then hold region size inside the new virtual sensor
    always_comb begin
        sc_val = (|sc_quo[DIM_W+1:DIM_W]) ? '1 : sc_quo[DIM_W-1:0];
        if (idx_q == F_ROI_W && sc_val > eff_width_q) begin
            sc_val = eff_width_q;
        end else if (idx_q == F_ROI_H && sc_val > eff_height_q) begin
            sc_val = eff_height_q;
        end
    end

    // walk all fields once per factor change, old to new coordinates
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_q    <= ST_IDLE;
            idx_q   <= '0;
            busy_q  <= 1'b0;
            app_h_q <= FAC_OFF;
            app_v_q <= FAC_OFF;
            old_h_q <= FAC_OFF;
            old_v_q <= FAC_OFF;
            new_h_q <= FAC_OFF;
            new_v_q <= FAC_OFF;
        end else if (ce) begin
            case (st_q)
                ST_IDLE: begin
                    if (pending) begin
                        old_h_q <= app_h_q;
                        old_v_q <= app_v_q;
                        new_h_q <= bin_h_q;
                        new_v_q <= bin_v_q;
                        app_h_q <= bin_h_q;
                        app_v_q <= bin_v_q;
                        idx_q   <= '0;
                        busy_q  <= 1'b1;
                        st_q    <= ST_SCALE;
                    end
                end
                ST_SCALE: begin
                    if (idx_q == FIDX_W'(NFIELD - 1)) begin
                        busy_q <= 1'b0;
                        st_q   <= ST_IDLE;
                    end else begin
                        idx_q <= idx_q + 4'h1;
                    end
                end
                default: begin
                    busy_q <= 1'b0;
                    st_q   <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // geometry fields
    ////////////////////////////////////////////////////////////////////////

    // writes refused while a rescale is due or running
    assign geom_ok = geom_wr && (st_q == ST_IDLE) && !pending && !busy_q;

    // region size writes limited to the virtual sensor
    always_comb begin
        wr_val = geom_wdata;
        if (geom_idx == F_ROI_W && geom_wdata > eff_width_q) begin
            wr_val = eff_width_q;
        end else if (geom_idx == F_ROI_H && geom_wdata > eff_height_q) begin
            wr_val = eff_height_q;
        end
    end

    // one register per field
    for (genvar g = 0; g < NFIELD; g++) begin : g_fld
        localparam dim_t RST = (g == int'(F_ROI_W)) ? SENSOR_W :
                               (g == int'(F_ROI_H)) ? SENSOR_H : '0;
        always_ff @(posedge mclk) begin
            if (!resetn) begin
                geom_q[g] <= RST;
            end else if (ce) begin
                if (st_q == ST_SCALE && idx_q == FIDX_W'(g)) begin
                    geom_q[g] <= sc_val;
                end else if (geom_ok && geom_idx == FIDX_W'(g)) begin
                    geom_q[g] <= wr_val;
                end
            end
        end
    end

    // read back; unknown index reads zero
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            geom_rdata_q <= '0;
        end else if (ce) begin
            geom_rdata_q <= (geom_rd_idx < FIDX_W'(NFIELD)) ? geom_q[geom_rd_idx] : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-frame settings
    ////////////////////////////////////////////////////////////////////////

    // factors change only at frame start, never mid frame
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            bin_h_act_q <= FAC_OFF;
            bin_v_act_q <= FAC_OFF;
            skip_act_q  <= SKIP_OFF;
            eff_w_act_q <= SENSOR_W;
            eff_h_act_q <= SENSOR_H;
        end else if (ce && pix_valid && pix_sof) begin
            bin_h_act_q <= bin_h_q;
            bin_v_act_q <= bin_v_q;
            skip_act_q  <= row_skip_factor_q;
            eff_w_act_q <= eff_width_q;
            eff_h_act_q <= eff_height_q;
        end
    end

    // first pixel of a frame already sees the new values
    assign hfac      = pix_sof ? bin_h_q : bin_h_act_q;
    assign hmax      = pix_sof ? eff_width_q : eff_w_act_q;
    assign lnk.sof   = pix_valid && pix_sof;
    assign lnk.sol   = pix_valid && pix_sol;
    assign lnk.bin_v = pix_sof ? bin_v_q : bin_v_act_q;
    assign lnk.skip  = pix_sof ? row_skip_factor_q : skip_act_q;
    assign lnk.eff_h = pix_sof ? eff_height_q : eff_h_act_q;

    row_selector #(
        .IS_COLOUR (IS_COLOUR)
    ) u_rows (
        .mclk   (mclk),
        .resetn (resetn),
        .ce     (ce),
        .lnk    (lnk.sel)
    );

    ////////////////////////////////////////////////////////////////////////
    // column grouping
    ////////////////////////////////////////////////////////////////////////

    assign hcur_ph  = pix_sol ? '0 : hphase_q;
    assign hcur_grp = pix_sol ? '0 : hgrp_q;
    assign col_keep = hcur_grp < hmax;
    assign hlast    = (hcur_ph == hfac - FAC_OFF);

    // column counters step on each valid pixel
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            hphase_q <= '0;
            hgrp_q   <= '0;
        end else if (ce && pix_valid) begin
            if (hlast) begin
                hphase_q <= '0;
                hgrp_q   <= hcur_grp + DIM_ONE;
            end else begin
                hphase_q <= hcur_ph + FAC_OFF;
                hgrp_q   <= hcur_grp;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit stream
    ////////////////////////////////////////////////////////////////////////

    // pass kept pixels with group markers for the combiner downstream
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            out_valid_q     <= 1'b0;
            out_sof_q       <= 1'b0;
            out_data_q      <= '0;
            out_hlast_q     <= 1'b0;
            out_vlast_q     <= 1'b0;
            row_skip_next_q <= 1'b0;
        end else if (ce) begin
            out_valid_q <= pix_valid && col_keep && lnk.row_keep;
            out_sof_q   <= pix_valid && pix_sof;
            out_data_q  <= pix_data;
            out_hlast_q <= hlast;
            out_vlast_q <= lnk.vgrp_last;
            // readout may skip the coming row entirely
            if (lnk.sol) begin
                row_skip_next_q <= !lnk.next_keep;
            end
        end
    end

endmodule

`default_nettype wire

// ### pbd_sva.sv
// port checker for the binning block, bound to its top
// assumes ce held high; mono or colour build
`default_nettype none
module pbd_sva
    import geom_pkg::*;
#(
    parameter dim_t SENSOR_W = SENSOR_W_DEF,
    parameter dim_t SENSOR_H = SENSOR_H_DEF,
    parameter bit   IS_COLOUR = 1'b0
)(
    // clock, reset, stimulus
    input wire logic  mclk, resetn, bin_h_wr, pix_valid, pix_sol, pix_sof,
    input wire skip_t set_wdata,
    // design outputs
    input wire logic  out_valid_q, row_skip_next_q, busy_q, gain_min_low_q,
    input wire fac_t  bin_h_q, bin_v_q,
    input wire skip_t row_skip_factor_q,
    input wire dim_t  eff_width_q, eff_height_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    dim_t rows_q; // rows begun in this frame
    always_ff @(posedge mclk) if (pix_valid && pix_sol) rows_q <= pix_sof ? DIM_ONE : rows_q + DIM_ONE;
    property p_fac; bin_h_wr && set_wdata inside {[1:4]} |=> 6'(bin_h_q) == $past(set_wdata); endproperty
    a_fac: assert property (p_fac) else $error("factor not taken");
    property p_eff; eff_width_q == SENSOR_W / $past(bin_h_q) && eff_height_q == SENSOR_H / $past(bin_v_q); endproperty
    a_eff: assert property (p_eff) else $error("bad size");
    property p_excl; !(bin_v_q != FAC_OFF && row_skip_factor_q != SKIP_OFF); endproperty
    a_excl: assert property (p_excl) else $error("both on");
    property p_hind; !bin_h_wr |=> $stable(bin_h_q); endproperty
    a_hind: assert property (p_hind) else $error("h factor moved");
    property p_gain; (bin_v_q != FAC_OFF) [*2] |-> gain_min_low_q == !IS_COLOUR; endproperty
    a_gain: assert property (p_gain) else $error("gain limit");
    property p_nopix; out_valid_q |-> $past(pix_valid); endproperty
    a_nopix: assert property (p_nopix) else $error("no source pixel");
    property p_walk; $rose(busy_q) |-> busy_q [*8] ##1 busy_q ##1 busy_q ##1 !busy_q; endproperty
    a_walk: assert property (p_walk) else $error("walk length");
    property p_next; pix_valid && pix_sol && (pix_sof || rows_q < SENSOR_H - DIM_ONE)
        && row_skip_factor_q == SKIP_OFF && bin_v_q == FAC_OFF |=> !row_skip_next_q; endproperty
    a_next: assert property (p_next) else $error("row skipped");
endmodule
bind pixel_binning_decimation pbd_sva #(.SENSOR_W(SENSOR_W), .SENSOR_H(SENSOR_H), .IS_COLOUR(IS_COLOUR)) u_chk (.*);
`default_nettype wire

// ### pix_src.sv
// sensor readout model: one 8 x 8 frame per go pulse
// assumes go is one mclk cycle wide
`default_nettype none
module pix_src
    import geom_pkg::*;
(
    input  wire logic        mclk, go,
    output logic             pix_valid, pix_sof, pix_sol,
    output logic [PIX_W-1:0] pix_data
);
    timeunit 1ns;
    timeprecision 1ps;
    int c = 0, r = 8, t = 0; // column, row (8 idle), free count
    // walk the frame a pixel a cycle
    always @(posedge mclk) begin
        t <= t + 1;
        c <= go ? 0 : (c + 1) % 8;
        r <= go ? 0 : r + int'(r < 8 && c == 7);
    end
    assign pix_valid = r < 8;
    assign pix_sol   = pix_valid && c == 0;
    assign pix_sof   = pix_sol && r == 0;
    assign pix_data  = pix_valid ? PIX_W'(r * 8 + c) : PIX_W'(t); // idle data keeps moving
endmodule
`default_nettype wire

// ### tb_top.sv
// bench for the binning block: factors, region rescale, pixel frames
// assumes an 8 x 8 sensor fed by pix_src
`default_nettype none
module tb_top import geom_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, resetn = 0, ce = 1, go = 0, geom_wr = 0, bin_h_wr = 0, bin_v_wr = 0, row_skip_factor_wr = 0;
    logic pix_valid, pix_sof, pix_sol, out_valid_q, out_hlast_q, busy_q, ev = 0;
    logic out_sof_q, out_vlast_q, row_skip_next_q, cv; // cv: colour build kept pixel
    logic [FIDX_W-1:0] geom_rd_idx = F_ROI_W, geom_idx = F_OFF_X;
    logic [PIX_W-1:0]  pix_data, out_data_q;
    skip_t             set_wdata = SKIP_OFF;
    fac_t              bin_h_q, bin_v_q;
    dim_t              eff_width_q, geom_rdata_q, geom_wdata = 16'h0007;
    integer            seed = 32'h0000_52ec;
    int err_total = 0, samples_checked = 0, cyc = 0, ebh = 1, ebv = 1, esk = 1, rw = 8, ox = 0, er, ec, zy = 7;
    int tbl [6][3] = '{'{3, 3, 1}, '{1, 1, 2}, '{2, 4, 1}, '{4, 1, 3}, '{1, 2, 1}, '{1, 1, 1}};
    pixel_binning_decimation #(.SENSOR_W(16'h0008), .SENSOR_H(16'h0008)) dut (.*, .row_skip_factor_q(),
        .eff_height_q(), .gain_min_low_q());
    pixel_binning_decimation #(16'h0008, 16'h0008, 1'b1) dut_colour (.*, .out_valid_q(cv), .out_sof_q(),
        .out_data_q(), .out_hlast_q(), .out_vlast_q(), .row_skip_next_q(), .bin_h_q(), .bin_v_q(),
        .row_skip_factor_q(), .eff_width_q(), .eff_height_q(), .geom_rdata_q(), .busy_q(), .gain_min_low_q());
    pix_src src (.*);
    always #12.5 mclk = ~mclk;
    // capture each pixel; cycle ceiling
    always @(posedge mclk) begin
        ev <= pix_valid;
        er <= src.r;
        ec <= src.c;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    // stream compare on settled outputs
    always @(negedge mclk) begin
        if (ev) chk(16'({cv, out_valid_q}), 16'({keep(er, ec, 1'b1), keep(er, ec)}));
        if (ev) chk(16'({out_sof_q, out_data_q}), 16'({er == 0 && ec == 0, PIX_W'(er * 8 + ec)}));
        if (ev && keep(er, ec)) chk(16'({out_hlast_q, out_vlast_q}),
            16'({ec % ebh == ebh - 1, er % ebv == ebv - 1}));
        if (ev && ec == 0) chk(16'(row_skip_next_q), 16'(!keep(er + 1, 0)));
    end
    function automatic bit keep(int r, int c, bit col = 1'b0);
        return (c / ebh < 8 / ebh) && (r / ebv < 8 / ebv) && ((col ? r / 2 : r) % esk == 0);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // factor write, then wait out the rescale walk
    task automatic wr(input int s, input int v);
        @(posedge mclk);
        {bin_h_wr, bin_v_wr, row_skip_factor_wr} <= 3'(4 >> s);
        set_wdata <= 6'(v);
        @(posedge mclk);
        {bin_h_wr, bin_v_wr, row_skip_factor_wr} <= 3'h0;
        repeat (3) @(posedge mclk);
        for (int i = 0; i < 20 && busy_q; i++) @(posedge mclk);
    endtask
    task automatic rd(input logic [FIDX_W-1:0] i, input int e);
        @(posedge mclk);
        geom_rd_idx <= i;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk(geom_rdata_q, 16'(e));
    endtask
    // set factors, check geometry, run one frame
    task automatic setf(input int h, input int v, input int s);
        wr(0, h);
        rw = rw * ebh / h;
        if (rw > 8 / h) rw = 8 / h;
        ox = ox * ebh / h;
        ebh = h;
        wr(1, v);
        zy = zy * ebv / v;
        wr(2, s);
        if (s > 1) zy = zy * v;
        ebv = (s > 1) ? 1 : v;
        esk = s;
        rd(F_ROI_W, rw);
        rd(F_OFF_X, ox);
        rd(F_ZONE_Y0, zy);
        chk(16'(bin_v_q), 16'(ebv));
        chk(eff_width_q, 16'(8 / ebh));
        @(posedge mclk);
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        repeat (70) @(posedge mclk);
    endtask
    task automatic give_verdict;
        $display("compares %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        geom_wr <= 1'b1;
        @(posedge mclk);
        geom_idx <= F_ZONE_Y0;
        @(posedge mclk);
        geom_wr <= 1'b0;
        ox = 7;
        foreach (tbl[i]) setf(tbl[i][0], tbl[i][1], tbl[i][2]);
        for (int i = 0; i < 5; i++) begin
            setf({$random(seed)} % 4 + 1, {$random(seed)} % 4 + 1, {$random(seed)} % 5 + 1);
        end
        wr(0, 5);
        @(negedge mclk);
        chk(16'(bin_h_q), 16'(ebh));
        give_verdict();
    end
endmodule
`default_nettype wire
